// ---- rtl/twl_pkg.sv ----
// Purpose: shared constants and types for the tag write/lock/select command block
// Assumes: 50 MHz system clock
// Notes:   command codes, error codes, flag positions and timing
package twl_pkg;
  localparam logic [7:0] CMD_WRITE_BLOCK = 8'h21;
  localparam logic [7:0] CMD_LOCK_BLOCK  = 8'h22;
  localparam logic [7:0] CMD_SELECT      = 8'h25;

  localparam logic [7:0] ERR_OTHER       = 8'h0F;
  localparam logic [7:0] ERR_ADDR_NA     = 8'h10;
  localparam logic [7:0] ERR_ALREADY_LCK = 8'h11;
  localparam logic [7:0] ERR_LOCKED      = 8'h12;
  localparam logic [7:0] ERR_NOT_PROG    = 8'h13;
  localparam logic [7:0] ERR_NOT_LOCKED  = 8'h14;

  // request flag bit positions
  localparam int FLG_SELECT  = 4;
  localparam int FLG_ADDRESS = 5;
  // response flag: error indicator
  localparam logic [7:0] RSP_FLAGS_OK  = 8'h00;
  localparam logic [7:0] RSP_FLAGS_ERR = 8'h01;

  localparam int  CLK_HZ          = 50_000_000;
  localparam int  CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;
  // programming cycle: nominal response delay plus 18 periods of 302 us
  localparam int  PROG_PERIODS    = 18;
  localparam int  PROG_PERIOD_US  = 302;
  localparam int  PROG_EXTRA_CYC  = (PROG_PERIODS * PROG_PERIOD_US * 1000) / CLK_PERIOD_NS;
  // nominal response delay, in ns
  localparam int  RESP_DELAY_NS   = 320_900;
  localparam int  RESP_DELAY_CYC  = (RESP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int  TIMER_W         = 20;

  typedef enum logic [1:0] {
    TWL_READY,
    TWL_SELECTED,
    TWL_QUIET
  } twl_tag_state_e;
endpackage

// ---- rtl/twl_mem_if.sv ----
// Purpose: memory write/lock port between the command block and its memory side
// Assumes: single clock domain
// Notes:   request held until done pulses
`timescale 1ns/100ps
`default_nettype none
interface twl_mem_if;
  logic        start;      // one-cycle start pulse
  logic        is_lock;    // lock rather than write
  logic [7:0]  block;      // block number
  logic [31:0] data;       // data to program
  logic        done;       // one-cycle completion pulse
  logic        ok;         // operation verified

  modport ctrl (output start, output is_lock, output block, output data, input done, input ok);
  modport exec (input start, input is_lock, input block, input data, output done, output ok);
endinterface
`default_nettype wire

// ---- rtl/twl_delay_timer.sv ----
// Purpose: counts a response delay or a programming cycle in clock cycles
// Assumes: load pulses only when idle
// Notes:   expired is a one-cycle pulse
`timescale 1ns/100ps
`default_nettype none
module twl_delay_timer #(
  parameter int TIMER_W = twl_pkg::TIMER_W
) (
  input  wire logic               clk,      // system clock
  input  wire logic               sys_rst,  // sync reset, active high
  input  wire logic               load,     // start counting
  input  wire logic [TIMER_W-1:0] count,    // cycles to wait
  output logic                    busy,     // counting
  output logic                    expired   // pulse at end
);
  logic [TIMER_W-1:0] cnt_reg;

  // down counter, expiry pulse at one
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= '0;
      expired <= 1'b0;
    end else if (load) begin
      cnt_reg <= count;
      expired <= 1'b0;
    end else begin
      expired <= (cnt_reg == TIMER_W'(1));
      if (cnt_reg != '0) begin
        cnt_reg <= cnt_reg - TIMER_W'(1);
      end
    end
  end

  assign busy = (cnt_reg != '0);

  // expiry follows exactly one cycle after the count reaches one
  property p_expire;
    @(posedge clk) disable iff (sys_rst)
      (busy && cnt_reg == TIMER_W'(1) && !load) |=> expired;
  endproperty
  a_expire: assert property (p_expire) else $error("timer did not expire");
endmodule
`default_nettype wire

// ---- rtl/twl_cmd_ctrl.sv ----
// Purpose: write-block, lock-block and select command handling for a vicinity tag
// Assumes: decoded request fields arrive with a one-cycle valid and a CRC verdict
// Notes:   memory array access is external; this block sequences and answers
`timescale 1ns/100ps
`default_nettype none
// What this block does
// RULE_01 - A write request carries flags, code 21h, optional serial id, block number and 32 data bits, which get stored.
// RULE_02 - The reader must not modulate while the tag programs or locks memory.
// RULE_03 - Programming lasts the nominal response delay plus 18 periods of 302 us and completes before the answer.
// RULE_04 - A good write is answered after programming with response flags only.
// RULE_05 - A failed write sets the error flag with code 10h, 12h or 13h.
// RULE_06 - A lock request carries flags, code 22h, optional serial id and block number, and locks the block.
// RULE_07 - A good lock is answered with response flags only.
// RULE_08 - A failed lock sets the error flag with code 10h, 11h or 14h.
// RULE_09 - A select request carries flags, code 25h and a mandatory serial id.
// RULE_10 - A matching select enters or keeps the Selected state and answers.
// RULE_11 - A non-matching select drops a selected tag to Ready with no answer.
// RULE_12 - A select error is reported with code 0Fh only when the serial id matched; the code never reports a select error.
// RULE_13 - A quiet tag that is selected goes to the Selected state.
// RULE_14 - Addressed mode is select flag 0 and address flag 1, and then the serial id is compared.
// RULE_15 - A write or lock failing before programming answers after the normal response delay only.
// RULE_16 - Requests with bad CRC or a mismatched id in addressed mode are dropped without memory action.
module twl_cmd_ctrl #(
  parameter int          BLOCK_COUNT = 64,                 // available blocks
  parameter logic [63:0] OWN_ID      = 64'h0123456789ABCDEF, // arbitrary value
  parameter int          RESP_CYC    = twl_pkg::RESP_DELAY_CYC,
  parameter int          PROG_CYC    = twl_pkg::PROG_EXTRA_CYC
) (
  input  wire logic        clk,           // system clock
  input  wire logic        sys_rst,       // sync reset, active high
  input  wire logic        req_valid,     // decoded request pulse
  input  wire logic        req_crc_ok,    // crc check passed
  input  wire logic [7:0]  req_flags,     // request flags
  input  wire logic [7:0]  req_cmd,       // command code
  input  wire logic        req_id_valid,  // serial id field present
  input  wire logic [63:0] req_serial_id, // tag_serial_id field
  input  wire logic [7:0]  req_block,     // block number
  input  wire logic [31:0] req_data,      // block data
  input  wire logic        blk_locked,    // addressed block lock status
  input  wire logic        quiet_in,      // quiet entered by other logic
  output logic             busy,          // command in progress
  output logic             prog_active,   // programming, no modulation
  output logic             rsp_valid,     // response frame pulse
  output logic [7:0]       rsp_flags,     // response flags
  output logic             rsp_has_code,  // error code present
  output logic [7:0]       rsp_code,      // error code
  output logic [1:0]       tag_state,     // current tag state
  output logic             mem_start,     // memory operation start
  output logic             mem_is_lock,   // lock versus write
  output logic [7:0]       mem_block,     // block number
  output logic [31:0]      mem_data,      // data to write
  input  wire logic        mem_done,      // memory operation done
  input  wire logic        mem_ok         // memory verify result
);
  typedef enum logic [2:0] {
    TWL_IDLE,
    TWL_PROG,
    TWL_WAIT,
    TWL_ANSWER
  } twl_seq_e;

  twl_seq_e                   seq_reg;
  twl_pkg::twl_tag_state_e    tag_reg;
  logic [7:0]                 code_reg;
  logic                       err_reg;
  logic                       is_lock_reg;
  logic                       prog_done_reg;
  logic                       wait_prog_reg;
  logic                       tmr_load;
  logic [twl_pkg::TIMER_W-1:0] tmr_count;
  logic                       tmr_busy;
  logic                       tmr_expired;
  logic                       addressed;
  logic                       id_match;
  logic                       accept;
  logic                       blk_ok;
  logic                       is_wr;
  logic                       is_lk;
  logic                       is_sel;
  logic                       pre_fail;
  logic [7:0]                 pre_code;

  twl_mem_if mif ();

  // request qualification
  assign addressed = !req_flags[twl_pkg::FLG_SELECT] && req_flags[twl_pkg::FLG_ADDRESS]; // RULE_14
  assign id_match  = req_id_valid && (req_serial_id == OWN_ID);                             // RULE_14
  assign accept    = req_valid && req_crc_ok && (seq_reg == TWL_IDLE)
                     && (!addressed || id_match);                                           // RULE_16
  assign is_wr     = (req_cmd == twl_pkg::CMD_WRITE_BLOCK);                                 // RULE_01
  assign is_lk     = (req_cmd == twl_pkg::CMD_LOCK_BLOCK);                                  // RULE_06
  assign is_sel    = (req_cmd == twl_pkg::CMD_SELECT);                                      // RULE_09
  assign blk_ok    = ({24'h000000, req_block} < 32'(BLOCK_COUNT));

  // pre-programming error checks
  always_comb begin
    pre_fail = 1'b0;
    pre_code = twl_pkg::ERR_OTHER;
    if (!blk_ok) begin
      pre_fail = 1'b1;
      pre_code = twl_pkg::ERR_ADDR_NA;                                    // RULE_05
    end else if (blk_locked) begin
      pre_fail = 1'b1;
      pre_code = is_lk ? twl_pkg::ERR_ALREADY_LCK : twl_pkg::ERR_LOCKED; // RULE_08
    end
  end

  // timer loads: response delay or programming cycle
  always_comb begin
    tmr_load  = 1'b0;
    tmr_count = twl_pkg::TIMER_W'(RESP_CYC);
    if (accept && (is_wr || is_lk) && pre_fail) begin
      tmr_load = 1'b1;                                   // RULE_15
    end else if (accept && is_sel && id_match) begin
      tmr_load = 1'b1;
    end else if (seq_reg == TWL_PROG && prog_done_reg) begin
      tmr_load  = 1'b1;
      tmr_count = twl_pkg::TIMER_W'(RESP_CYC + PROG_CYC); // RULE_03
    end
  end

  twl_delay_timer #(
    .TIMER_W (twl_pkg::TIMER_W)
  ) u_timer (
    .clk     (clk),
    .sys_rst (sys_rst),
    .load    (tmr_load),
    .count   (tmr_count),
    .busy    (tmr_busy),
    .expired (tmr_expired)
  );

  // sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seq_reg <= TWL_IDLE;
    end else begin
      unique case (seq_reg)
        TWL_IDLE: begin
          if (accept && (is_wr || is_lk) && !pre_fail) begin
            seq_reg <= TWL_PROG;                      // RULE_01
          end else if (tmr_load) begin
            seq_reg <= TWL_WAIT;
          end
        end
        TWL_PROG: begin
          if (prog_done_reg) begin
            seq_reg <= TWL_WAIT;                      // RULE_04
          end
        end
        TWL_WAIT: begin
          if (tmr_expired) begin
            seq_reg <= TWL_ANSWER;
          end
        end
        TWL_ANSWER: seq_reg <= TWL_IDLE;
        default:    seq_reg <= TWL_IDLE;
      endcase
    end
  end

  // error code and command kind capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_reg     <= 1'b0;
      code_reg    <= twl_pkg::ERR_OTHER;
      is_lock_reg <= 1'b0;
    end else if (accept && (is_wr || is_lk)) begin
      err_reg     <= pre_fail;
      code_reg    <= pre_code;
      is_lock_reg <= is_lk;
    end else if (accept && is_sel && id_match) begin
      err_reg     <= 1'b0;                            // RULE_12
      code_reg    <= twl_pkg::ERR_OTHER;
    end else if (seq_reg == TWL_PROG && mif.done && !mif.ok) begin
      err_reg     <= 1'b1;
      code_reg    <= is_lock_reg ? twl_pkg::ERR_NOT_LOCKED : twl_pkg::ERR_NOT_PROG; // RULE_08
    end
  end

  // memory completion latch
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      prog_done_reg <= 1'b0;
    end else begin
      prog_done_reg <= (seq_reg == TWL_PROG) && mif.done && !prog_done_reg;
    end
  end

  // marks a wait that follows a memory operation, not a plain response delay
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_prog_reg <= 1'b0;
    end else if (seq_reg == TWL_PROG) begin
      wait_prog_reg <= 1'b1;
    end else if (seq_reg == TWL_IDLE) begin
      wait_prog_reg <= 1'b0;
    end
  end

  // memory port drive
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mif.start   <= 1'b0;
      mif.is_lock <= 1'b0;
      mif.block   <= 8'h00;
      mif.data    <= 32'h00000000;
    end else begin
      mif.start <= accept && (is_wr || is_lk) && !pre_fail; // RULE_16
      if (accept) begin
        mif.is_lock <= is_lk;                                // RULE_06
        mif.block   <= req_block;
        mif.data    <= req_data;                             // RULE_01
      end
    end
  end

  assign mif.done    = mem_done;
  assign mif.ok      = mem_ok;
  assign mem_start   = mif.start;
  assign mem_is_lock = mif.is_lock;
  assign mem_block   = mif.block;
  assign mem_data    = mif.data;

  // tag state transitions on select and on quiet_in
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tag_reg <= twl_pkg::TWL_READY;
    end else if (req_valid && req_crc_ok && is_sel && seq_reg == TWL_IDLE) begin
      if (id_match) begin
        tag_reg <= twl_pkg::TWL_SELECTED;             // RULE_10 RULE_13
      end else if (tag_reg == twl_pkg::TWL_SELECTED) begin
        tag_reg <= twl_pkg::TWL_READY;                // RULE_11
      end
    end else if (quiet_in) begin
      tag_reg <= twl_pkg::TWL_QUIET;
    end
  end

  // response frame
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid    <= 1'b0;
      rsp_flags    <= twl_pkg::RSP_FLAGS_OK;
      rsp_has_code <= 1'b0;
      rsp_code     <= 8'h00;
    end else begin
      rsp_valid <= (seq_reg == TWL_WAIT) && tmr_expired;            // RULE_04 RULE_07
      if ((seq_reg == TWL_WAIT) && tmr_expired) begin
        rsp_flags    <= err_reg ? twl_pkg::RSP_FLAGS_ERR : twl_pkg::RSP_FLAGS_OK; // RULE_05
        rsp_has_code <= err_reg;
        rsp_code     <= err_reg ? code_reg : 8'h00;
      end
    end
  end

  assign busy        = (seq_reg != TWL_IDLE);
  assign prog_active = (seq_reg == TWL_PROG) || ((seq_reg == TWL_WAIT) && wait_prog_reg && tmr_busy); // RULE_02
  assign tag_state   = tag_reg;

  // a request with bad CRC never starts the memory
  property p_no_mem_on_bad;
    @(posedge clk) disable iff (sys_rst)
      (req_valid && !req_crc_ok) |=> !mem_start;
  endproperty
  a_no_mem_on_bad: assert property (p_no_mem_on_bad) else $error("memory started on bad request"); // RULE_16

  // mismatched select from selected state gives ready
  property p_sel_miss;
    @(posedge clk) disable iff (sys_rst)
      (req_valid && req_crc_ok && is_sel && !id_match && seq_reg == TWL_IDLE
       && tag_reg == twl_pkg::TWL_SELECTED) |=> (tag_reg == twl_pkg::TWL_READY);
  endproperty
  a_sel_miss: assert property (p_sel_miss) else $error("select miss kept selected"); // RULE_11

  // matching select enters selected
  property p_sel_hit;
    @(posedge clk) disable iff (sys_rst)
      (req_valid && req_crc_ok && is_sel && id_match && seq_reg == TWL_IDLE)
      |=> (tag_reg == twl_pkg::TWL_SELECTED);
  endproperty
  a_sel_hit: assert property (p_sel_hit) else $error("select hit not selected"); // RULE_10

  // no answer while programming
  property p_quiet_prog;
    @(posedge clk) disable iff (sys_rst)
      (seq_reg == TWL_PROG) |-> !rsp_valid;
  endproperty
  a_quiet_prog: assert property (p_quiet_prog) else $error("answer during programming"); // RULE_04

  // answers with an error code always carry the error flag
  property p_err_frame;
    @(posedge clk) disable iff (sys_rst)
      (rsp_valid && rsp_has_code) |-> (rsp_flags == twl_pkg::RSP_FLAGS_ERR);
  endproperty
  a_err_frame: assert property (p_err_frame) else $error("error code without error flag"); // RULE_05

  // out of range block on a write request answers 10h
  property p_addr_na;
    @(posedge clk) disable iff (sys_rst)
      (accept && is_wr && !blk_ok) |=> (code_reg == twl_pkg::ERR_ADDR_NA && err_reg);
  endproperty
  a_addr_na: assert property (p_addr_na) else $error("bad block code wrong"); // RULE_05

  // locked block on lock request answers 11h
  property p_relock;
    @(posedge clk) disable iff (sys_rst)
      (accept && is_lk && blk_ok && blk_locked) |=> (code_reg == twl_pkg::ERR_ALREADY_LCK);
  endproperty
  a_relock: assert property (p_relock) else $error("relock code wrong"); // RULE_08

  // good write starts memory next cycle
  property p_wr_start;
    @(posedge clk) disable iff (sys_rst)
      (accept && is_wr && !pre_fail) |=> (mem_start && !mem_is_lock);
  endproperty
  a_wr_start: assert property (p_wr_start) else $error("write did not start"); // RULE_01
endmodule
`default_nettype wire

// ---- tb/twl_mem_model.sv ----
// Purpose: memory side model that answers write and lock operations
// Assumes: one operation at a time, started by a one-cycle pulse
// Notes:   done comes after a short or long delay; verify result can be forced bad
`timescale 1ns/100ps
`default_nettype none
module twl_mem_model (
  input  wire logic        clk,         // system clock
  input  wire logic        sys_rst,     // sync reset, active high
  input  wire logic        mem_start,   // operation start
  input  wire logic        mem_is_lock, // lock rather than write
  input  wire logic [7:0]  mem_block,   // block number
  input  wire logic [31:0] mem_data,    // data to store
  input  wire logic        fail_op,     // make the next operation fail
  input  wire logic        slow,        // long programming delay
  input  wire logic [7:0]  q_block,     // block whose lock bit is asked
  output logic             q_locked,    // lock bit of q_block
  output logic             mem_done,    // completion pulse
  output logic             mem_ok       // verify result
);
  logic [31:0] store [64];
  logic [63:0] lock_reg;
  logic [3:0]  cnt_reg;
  logic        ok_reg;
  // lock status lookup, blocks past the array are never locked
  assign q_locked = (q_block < 8'h40) ? lock_reg[q_block[5:0]] : 1'b0;
  // verify result only valid with done; inverted otherwise
  assign mem_ok = mem_done ? ok_reg : ~ok_reg;
  // operation sequencing and storage
  always_ff @(posedge clk) begin
    mem_done <= 1'b0;
    if (sys_rst) begin
      cnt_reg  <= 4'h0;
      lock_reg <= '0;
      ok_reg   <= 1'b0;
    end else if (mem_start) begin
      cnt_reg <= slow ? 4'h8 : 4'h2;
      ok_reg  <= ~fail_op;
    end else if (cnt_reg == 4'h1) begin
      mem_done <= 1'b1;
      cnt_reg  <= 4'h0;
      if (ok_reg && mem_is_lock) lock_reg[mem_block[5:0]] <= 1'b1;
      else if (ok_reg) store[mem_block[5:0]] <= mem_data;
    end else if (cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule
`default_nettype wire

// ---- tb/tag_write_lock_select_cmds_tb_top.sv ----
// Purpose: self-checking bench for the write, lock and select command block
// Assumes: short response and programming counts set at the instance
// Notes:   requests driven at the falling edge, results sampled after the rising edge
`timescale 1ns/100ps
`default_nettype none
module tag_write_lock_select_cmds_tb_top;
  localparam int          RESP  = 4;
  localparam int          PROG  = 10;
  localparam logic [63:0] MY_ID = 64'h5A5A0F0F1234C3C3; // arbitrary value
  localparam logic [7:0]  WR = twl_pkg::CMD_WRITE_BLOCK;
  localparam logic [7:0]  LK = twl_pkg::CMD_LOCK_BLOCK;
  localparam logic [7:0]  SL = twl_pkg::CMD_SELECT;
  logic        clk, sys_rst, req_valid, req_crc_ok, req_id_valid, blk_locked, quiet_in;
  logic        busy, prog_active, rsp_valid, rsp_has_code, mem_start, mem_is_lock;
  logic        mem_done, mem_ok, fail_op, slow;
  logic [7:0]  req_flags, req_cmd, req_block, rsp_flags, rsp_code, mem_block, b;
  logic [63:0] req_serial_id;
  logic [31:0] req_data, mem_data, d;
  logic [1:0]  tag_state;
  int          n_fail, n_compared, n_ops, k, kd, n0, np;
  integer      seed;
  twl_cmd_ctrl #(.BLOCK_COUNT(64), .OWN_ID(MY_ID), .RESP_CYC(RESP), .PROG_CYC(PROG)) DUT (.clk, .sys_rst,
    .req_valid, .req_crc_ok, .req_flags, .req_cmd, .req_id_valid, .req_serial_id, .req_block, .req_data,
    .blk_locked, .quiet_in, .busy, .prog_active, .rsp_valid, .rsp_flags, .rsp_has_code, .rsp_code,
    .tag_state, .mem_start, .mem_is_lock, .mem_block, .mem_data, .mem_done, .mem_ok);
  twl_mem_model MEM (.clk, .sys_rst, .mem_start, .mem_is_lock, .mem_block, .mem_data, .fail_op, .slow,
    .q_block(req_block), .q_locked(blk_locked), .mem_done, .mem_ok);
  // clock, 20 ns period
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // count memory operations started
  always @(posedge clk) if (mem_start === 1'b1) n_ops++;
  // watchdog against a hang
  initial begin
    #400_000;
    n_fail++;
    conclude();
  end
  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  // response frame fields against the expected error code, 00h meaning success
  task automatic cmp_rsp(input logic [7:0] code);
    cmp(rsp_flags, (code == 8'h00) ? twl_pkg::RSP_FLAGS_OK : twl_pkg::RSP_FLAGS_ERR, "flags");
    cmp(rsp_has_code, code != 8'h00, "has code");
    cmp(rsp_code, code, "code");
  endtask
  // one request pulse, fields scrambled once released
  task automatic send(input logic [7:0] flg, cmd, blk, input logic [31:0] dat, input logic crc,
                      input logic [63:0] id);
    @(negedge clk);
    {req_flags, req_cmd, req_block, req_data, req_serial_id} = {flg, cmd, blk, dat, id};
    req_crc_ok = crc;
    req_id_valid = 1'b1;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    {req_flags, req_cmd, req_block, req_data, req_serial_id} = ~{flg, cmd, blk, dat, id};
    req_crc_ok = ~crc;
  endtask
  // cycles to the response; kd marks the cycle of memory completion
  task automatic wait_rsp(input int lim);
    k = 0;
    kd = -1;
    np = 0;
    repeat (lim) begin
      @(posedge clk);
      #1;
      k++;
      if (prog_active === 1'b1) np++;
      if (mem_done === 1'b1) begin
        kd = k;
        cmp(prog_active, 1'b1, "no modulation window");
      end
      if (rsp_valid === 1'b1) return;
    end
    k = -1;
  endtask
  // ek: -1 silent, 0 through programming, else exact delay
  task automatic op(input logic [7:0] flg, cmd, blk, input logic [31:0] dat, input logic crc,
                    input logic [63:0] id, input int ek, input logic [7:0] code);
    n0 = n_ops;
    send(flg, cmd, blk, dat, crc, id);
    wait_rsp(70);
    cmp(n_ops - n0, ek == 0, "memory ops");
    cmp(np > 0, ek == 0, "no modulation window");
    if (ek < 0) cmp(k, -1, "silence");
    else if (ek == 0) cmp(kd > 0 && k - kd >= PROG + RESP && k - kd <= PROG + RESP + 4, 1'b1, "prog wait");
    else cmp(k, ek, "delay");
    if (ek >= 0) cmp_rsp(code);
    repeat (50) if (busy !== 1'b0) @(negedge clk);
    cmp(busy, 1'b0, "idle");
    $display("request %0h to block %0h finished at %0t", cmd, blk, $time);
  endtask
  // main sequence
  initial begin
    seed = 11;
    {req_valid, req_crc_ok, req_id_valid, quiet_in, fail_op, slow} = '0;
    {req_flags, req_cmd, req_block, req_data, req_serial_id} = '0;
    sys_rst = 1'b1;
    repeat (16) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    cmp({rsp_valid, mem_start, busy, tag_state}, 0, "reset values");
    for (int i = 0; i < 6; i++) begin
      b = 8'($random(seed)) & 8'h3E;
      d = $random(seed);
      slow = 1'($random(seed));
      op(i[0] ? 8'h20 : 8'h00, WR, b, d, 1'b1, MY_ID, 0, 8'h00);
      cmp(MEM.store[b[5:0]], d, "stored data");
    end
    op(8'h00, WR, 8'h3F, 32'hA5A55A5A, 1'b1, MY_ID, 0, 8'h00);
    cmp(MEM.store[63], 32'hA5A55A5A, "stored data");
    op(8'h00, WR, 8'h40, 32'h1, 1'b1, MY_ID, RESP + 1, twl_pkg::ERR_ADDR_NA);
    fail_op = 1'b1;
    op(8'h00, WR, 8'h03, 32'h2, 1'b1, MY_ID, 0, twl_pkg::ERR_NOT_PROG);
    op(8'h00, LK, 8'h06, 32'h0, 1'b1, MY_ID, 0, twl_pkg::ERR_NOT_LOCKED);
    fail_op = 1'b0;
    op(8'h20, LK, 8'h05, 32'h0, 1'b1, MY_ID, 0, 8'h00);
    cmp(MEM.lock_reg[5], 1'b1, "block locked");
    op(8'h00, LK, 8'h05, 32'h0, 1'b1, MY_ID, RESP + 1, twl_pkg::ERR_ALREADY_LCK);
    op(8'h00, WR, 8'h05, 32'h3, 1'b1, MY_ID, RESP + 1, twl_pkg::ERR_LOCKED);
    op(8'h00, LK, 8'hC8, 32'h0, 1'b1, MY_ID, RESP + 1, twl_pkg::ERR_ADDR_NA);
    op(8'h00, WR, 8'h07, 32'h4, 1'b0, MY_ID, -1, 8'h00);
    op(8'h20, WR, 8'h07, 32'h4, 1'b1, ~MY_ID, -1, 8'h00);
    op(8'h20, LK, 8'h07, 32'h0, 1'b1, ~MY_ID, -1, 8'h00);
    slow = 1'b1;
    n0 = n_ops;
    send(8'h00, WR, 8'h09, 32'h5, 1'b1, MY_ID);
    send(8'h00, LK, 8'h09, 32'h0, 1'b1, MY_ID);
    wait_rsp(70);
    cmp(n_ops - n0, 1, "request while busy");
    cmp_rsp(8'h00);
    cmp(MEM.lock_reg[9], 1'b0, "lock while busy");
    repeat (50) if (busy !== 1'b0) @(negedge clk);
    op(8'h00, SL, 8'h00, 32'h0, 1'b1, MY_ID, RESP + 1, 8'h00);
    cmp(tag_state, twl_pkg::TWL_SELECTED, "selected");
    op(8'h00, SL, 8'h00, 32'h0, 1'b1, MY_ID, RESP + 1, 8'h00);
    cmp(tag_state, twl_pkg::TWL_SELECTED, "stays selected");
    op(8'h00, SL, 8'h00, 32'h0, 1'b1, MY_ID ^ 64'h1, -1, 8'h00);
    cmp(tag_state, twl_pkg::TWL_READY, "back to ready");
    @(negedge clk) quiet_in = 1'b1;
    @(negedge clk) quiet_in = 1'b0;
    cmp(tag_state, twl_pkg::TWL_QUIET, "quiet");
    op(8'h00, SL, 8'h00, 32'h0, 1'b1, MY_ID, RESP + 1, 8'h00);
    cmp(tag_state, twl_pkg::TWL_SELECTED, "quiet to selected");
    conclude();
  end
endmodule
`default_nettype wire
